// ---- acc_defines.vh ----
/*
 Shared constants of the analog comparator control block: register
 offsets, field positions, reset values and mode codes.
 Assumes inclusion by bare name from the design files.
*/
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH

// Register byte offsets
`define ACC_OFS_CTRL_B 12'h000
`define ACC_OFS_CSR 12'h004
`define ACC_OFS_DIDR 12'h008
`define ACC_OFS_IRQ_STAT 12'h00C
`define ACC_OFS_IRQ_MASK 12'h010

// converter_ctrl_b fields
`define ACC_B_BIPOLAR 7
`define ACC_B_MUX_EN 6
`define ACC_B_REF_HI 5
`define ACC_B_REF_LO 4
`define ACC_B_RSVD 3
`define ACC_B_TRIG_HI 2
`define ACC_B_TRIG_LO 0
`define ACC_CTRL_B_WMASK 8'hF7

// comparator_ctrl_status fields
`define ACC_C_POWER_OFF 7
`define ACC_C_INT_REF 6
`define ACC_C_OUT_SYNC 5
`define ACC_C_IRQ_FLAG 4
`define ACC_C_IRQ_EN 3
`define ACC_C_CAPTURE 2
`define ACC_C_MODE_HI 1
`define ACC_C_MODE_LO 0

// digital_input_disable fields
`define ACC_D_POS_OFF 7
`define ACC_D_NEG_OFF 6

// Interrupt status / mask layout
`define ACC_I_CMP_EVT 0
`define ACC_I_CAP_EVT 1
`define ACC_IRQ_BITS 2

// Reset values
`define ACC_RST_8 8'h00
`define ACC_RST_IRQ 2'h0
`define ACC_RST_32 32'h0000_0000

// Interrupt mode codes
`define ACC_MODE_TOGGLE 2'h0
`define ACC_MODE_RSVD 2'h1
`define ACC_MODE_FALL 2'h2
`define ACC_MODE_RISE 2'h3

// Input selection codes
`define ACC_CH_MAX 5'h0A
`define ACC_CH_CURRENT_SOURCE_NODE 5'h03
`define ACC_REF_FULL 2'h3

`endif

// ---- acc_sync.v ----
/*
 Two-flop synchronizer for the raw comparator output, with a third
 register holding the previous synchronized value for edge detection.
 Assumes the raw input is asynchronous to i_clk.
*/
`timescale 1ns/1ns
module acc_sync (
	input wire i_clk,
	input wire i_rst,
	input wire i_ce,
	input wire i_raw,
	output wire o_sync,
	output wire o_rise,
	output wire o_fall
);
	reg meta_reg;
	reg sync_reg;
	reg prev_reg;

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else if (i_ce) begin
			meta_reg <= i_raw;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign o_sync = sync_reg;
	assign o_rise = sync_reg & ~prev_reg;
	assign o_fall = ~sync_reg & prev_reg;
endmodule

// ---- acc_input_select.v ----
/*
 Routing decode for the comparator's positive and negative inputs.
 Assumes the analog switches follow these select levels directly.
*/
`timescale 1ns/1ns
`include "acc_defines.vh"
module acc_input_select (
	input wire i_mux_enable,
	input wire i_converter_enable,
	input wire [4:0] i_channel_select_code,
	input wire i_internal_ref_select,
	input wire [1:0] i_ref_level,
	input wire [1:0] i_converter_ref_field,
	output wire o_pos_from_mux,
	output wire [4:0] o_pos_channel,
	output wire o_pos_channel_valid,
	output wire o_current_source_node,
	output wire o_neg_from_ref,
	output wire [1:0] o_ref_level,
	output wire o_ref_valid
);
	assign o_pos_from_mux = i_mux_enable & ~i_converter_enable;
	assign o_pos_channel = o_pos_from_mux ? i_channel_select_code :
		5'h00;
	assign o_pos_channel_valid = o_pos_from_mux &
		(i_channel_select_code <= `ACC_CH_MAX);
	assign o_current_source_node = o_pos_from_mux &
		(i_channel_select_code == `ACC_CH_CURRENT_SOURCE_NODE);
	assign o_neg_from_ref = i_internal_ref_select;
	// Code 0 full scale, each step halves the level
	assign o_ref_level = i_internal_ref_select ? i_ref_level : 2'h0;
	assign o_ref_valid = i_internal_ref_select &
		(i_converter_ref_field == `ACC_REF_FULL);
endmodule

// ---- acc_top.v ----
/*
 Analog comparator control: APB register file, input routing,
 output synchronizer, interrupt flag and capture routing.
 Assumes the analog core, converter and timer sit outside.
*/
// Contract
// - Mux enable with converter off routes channel mux to positive input.
// - Otherwise the dedicated positive pin drives the positive input.
// - Channel codes 0..10 select channels; code 3 adds current source node.
// - Internal reference select feeds reference to negative input, else pin.
// - Two-bit level field picks reference only while internal select set.
// - Power-off bit removes comparator power, writable any time.
// - Comparator output synchronized to status bit, one to two cycles.
// - Flag set when synchronized output shows the selected mode event.
// - Flag clears on vector taken or software writing one.
// - Request only with flag, enable and global enable all set.
// - Mode 0 toggle, 1 reserved, 2 falling, 3 rising.
// - Capture route bit connects output to timer capture front end.
// - Comparator capture interrupt needs timer capture enable set.
// - Upper disable bits kill pin buffers; port bits read zero.
// - Status is one when positive input exceeds negative input.
// - With reference field 11b, levels full, half, quarter, eighth.
`timescale 1ns/1ns
`include "acc_defines.vh"
module acc_top (
	input wire i_clk,
	input wire i_rst,
	input wire i_ce,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output wire [31:0] o_prdata,
	output wire o_pready,
	output wire o_pslverr,
	input wire i_cmp_raw,
	input wire i_converter_enable,
	input wire [4:0] i_channel_select_code,
	input wire [1:0] i_converter_ref_field,
	input wire i_global_irq_enable,
	input wire i_cmp_vector_taken,
	input wire i_timer_capture_irq_enable,
	input wire i_timer_capture_flag,
	input wire i_pos_pin_digital,
	input wire i_neg_pin_digital,
	output wire o_pos_from_mux,
	output wire [4:0] o_pos_channel,
	output wire o_pos_channel_valid,
	output wire o_current_source_node,
	output wire o_neg_from_ref,
	output wire [1:0] o_ref_level,
	output wire o_ref_valid,
	output wire o_cmp_power_off,
	output wire o_cmp_output_sync,
	output wire o_cmp_irq_req,
	output wire o_capture_input,
	output wire o_capture_irq_req,
	output wire o_pos_pin_buffer_off,
	output wire o_neg_pin_buffer_off,
	output wire o_pos_pin_read,
	output wire o_neg_pin_read,
	output wire o_irq
);
	reg [7:0] ctrl_b_reg;
	reg [7:0] csr_reg;
	reg [7:0] didr_reg;
	reg [`ACC_IRQ_BITS-1:0] irq_stat_reg;
	reg [`ACC_IRQ_BITS-1:0] irq_mask_reg;
	reg flag_reg;
	reg cap_prev_reg;
	reg [31:0] prdata_reg;
	reg slverr_reg;

	wire cmp_sync;
	wire cmp_rise;
	wire cmp_fall;
	wire [1:0] mode;
	wire cmp_event;
	wire setup;
	wire wr_access;
	wire [7:0] wbyte;
	wire [7:0] csr_view;
	wire flag_w1c;
	wire cap_req;
	wire cap_event;
	reg [31:0] rd_mux;
	reg rd_hit;

	// Mode decode of edge strobes into a flag event
	function mode_event;
		input [1:0] m;
		input rise;
		input fall;
		begin
			case (m)
			`ACC_MODE_TOGGLE: mode_event = rise | fall;
			`ACC_MODE_FALL: mode_event = fall;
			`ACC_MODE_RISE: mode_event = rise;
			default: mode_event = 1'b0;
			endcase
		end
	endfunction

	// Address match against a register offset
	function addr_is;
		input [11:0] a;
		input [11:0] ofs;
		begin
			addr_is = (a == ofs);
		end
	endfunction

	acc_sync u_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_raw(i_cmp_raw),
		.o_sync(cmp_sync),
		.o_rise(cmp_rise),
		.o_fall(cmp_fall)
	);

	acc_input_select u_sel (
		.i_mux_enable(ctrl_b_reg[`ACC_B_MUX_EN]),
		.i_converter_enable(i_converter_enable),
		.i_channel_select_code(i_channel_select_code),
		.i_internal_ref_select(csr_reg[`ACC_C_INT_REF]),
		.i_ref_level(ctrl_b_reg[`ACC_B_REF_HI:`ACC_B_REF_LO]),
		.i_converter_ref_field(i_converter_ref_field),
		.o_pos_from_mux(o_pos_from_mux),
		.o_pos_channel(o_pos_channel),
		.o_pos_channel_valid(o_pos_channel_valid),
		.o_current_source_node(o_current_source_node),
		.o_neg_from_ref(o_neg_from_ref),
		.o_ref_level(o_ref_level),
		.o_ref_valid(o_ref_valid)
	);

	assign mode = csr_reg[`ACC_C_MODE_HI:`ACC_C_MODE_LO];
	assign cmp_event = mode_event(mode, cmp_rise, cmp_fall);

	assign setup = i_psel & ~i_penable;
	assign wr_access = i_psel & i_penable & i_pwrite;
	assign wbyte = i_pwdata[7:0];
	assign flag_w1c = wr_access & addr_is(i_paddr, `ACC_OFS_CSR) &
		wbyte[`ACC_C_IRQ_FLAG];

	assign csr_view = {csr_reg[`ACC_C_POWER_OFF], csr_reg[`ACC_C_INT_REF],
		cmp_sync, flag_reg, csr_reg[`ACC_C_IRQ_EN:`ACC_C_MODE_LO]};

	// Capture path and its gated interrupt
	assign o_capture_input = csr_reg[`ACC_C_CAPTURE] & cmp_sync;
	assign cap_req = csr_reg[`ACC_C_CAPTURE] & i_timer_capture_flag;
	assign cap_event = cap_req & ~cap_prev_reg;
	assign o_capture_irq_req = cap_req & i_timer_capture_irq_enable &
		i_global_irq_enable;

	always @* begin
		rd_mux = `ACC_RST_32;
		rd_hit = 1'b1;
		case (i_paddr)
		`ACC_OFS_CTRL_B: rd_mux[7:0] = ctrl_b_reg;
		`ACC_OFS_CSR: rd_mux[7:0] = csr_view;
		`ACC_OFS_DIDR: rd_mux[7:0] = didr_reg;
		`ACC_OFS_IRQ_STAT: rd_mux[`ACC_IRQ_BITS-1:0] = irq_stat_reg;
		`ACC_OFS_IRQ_MASK: rd_mux[`ACC_IRQ_BITS-1:0] = irq_mask_reg;
		default: rd_hit = 1'b0;
		endcase
	end

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_b_reg <= `ACC_RST_8;
			csr_reg <= `ACC_RST_8;
			didr_reg <= `ACC_RST_8;
			irq_stat_reg <= `ACC_RST_IRQ;
			irq_mask_reg <= `ACC_RST_IRQ;
			flag_reg <= 1'b0;
			cap_prev_reg <= 1'b0;
			prdata_reg <= `ACC_RST_32;
			slverr_reg <= 1'b0;
		end else if (i_ce) begin
			cap_prev_reg <= cap_req;
			if (setup) begin
				prdata_reg <= i_pwrite ? `ACC_RST_32 : rd_mux;
				slverr_reg <= ~rd_hit;
			end
			if (wr_access) begin
				case (i_paddr)
				`ACC_OFS_CTRL_B: ctrl_b_reg <= wbyte & `ACC_CTRL_B_WMASK;
				// Power-off write accepted in any state
				`ACC_OFS_CSR: csr_reg <= wbyte;
				`ACC_OFS_DIDR: didr_reg <= wbyte;
				`ACC_OFS_IRQ_MASK:
					irq_mask_reg <= wbyte[`ACC_IRQ_BITS-1:0];
				default: ;
				endcase
			end
			// Set wins over a clear in the same cycle
			flag_reg <= (flag_reg & ~(flag_w1c | i_cmp_vector_taken)) |
				cmp_event;
			if (wr_access & addr_is(i_paddr, `ACC_OFS_IRQ_STAT))
				irq_stat_reg <= (irq_stat_reg &
					~wbyte[`ACC_IRQ_BITS-1:0]) |
					{cap_event, cmp_event};
			else
				irq_stat_reg <= irq_stat_reg | {cap_event, cmp_event};
		end
	end

	assign o_prdata = prdata_reg;
	// Stall the access phase while the clock enable freezes state
	assign o_pready = i_ce;
	assign o_pslverr = i_psel & i_penable & slverr_reg;

	assign o_cmp_power_off = csr_reg[`ACC_C_POWER_OFF];
	assign o_cmp_output_sync = cmp_sync;
	assign o_cmp_irq_req = flag_reg & csr_reg[`ACC_C_IRQ_EN] &
		i_global_irq_enable;
	assign o_pos_pin_buffer_off = didr_reg[`ACC_D_POS_OFF];
	assign o_neg_pin_buffer_off = didr_reg[`ACC_D_NEG_OFF];
	assign o_pos_pin_read = i_pos_pin_digital &
		~didr_reg[`ACC_D_POS_OFF];
	assign o_neg_pin_read = i_neg_pin_digital &
		~didr_reg[`ACC_D_NEG_OFF];
	assign o_irq = |(irq_stat_reg & irq_mask_reg);
endmodule

// ---- acc_top_props.sv ----
/*
 Checker for the comparator control top: routing, synchronizer and
 interrupt gating relations at the ports.
 Assumes i_ce is held high by the bench.
*/
`timescale 1ns/1ns
module acc_top_props (
	input wire i_clk,
	input wire i_rst,
	input wire i_cmp_raw,
	input wire i_converter_enable,
	input wire [4:0] i_channel_select_code,
	input wire [1:0] i_converter_ref_field,
	input wire i_global_irq_enable,
	input wire i_timer_capture_irq_enable,
	input wire i_pos_pin_digital,
	input wire o_pos_from_mux,
	input wire [4:0] o_pos_channel,
	input wire o_pos_channel_valid,
	input wire o_current_source_node,
	input wire o_neg_from_ref,
	input wire [1:0] o_ref_level,
	input wire o_ref_valid,
	input wire o_cmp_output_sync,
	input wire o_cmp_irq_req,
	input wire o_capture_input,
	input wire o_capture_irq_req,
	input wire o_pos_pin_buffer_off,
	input wire o_pos_pin_read
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	AST_MUX_ROUTE: assert property (o_pos_from_mux |-> !i_converter_enable)
		else $error("mux routed while converter on");
	AST_POS_CH: assert property (o_pos_channel ==
		(o_pos_from_mux ? i_channel_select_code : 5'h00)) else $error("pos ch");
	AST_CH_VALID: assert property (o_pos_from_mux |->
		o_pos_channel_valid == (i_channel_select_code <= 5'h0A))
		else $error("channel valid wrong");
	AST_CURRENT_SOURCE_NODE: assert property (o_current_source_node ==
		(o_pos_from_mux && i_channel_select_code == 5'h03)) else $error("current_source_node");
	AST_REF_OFF: assert property (!o_neg_from_ref |->
		o_ref_level == 2'h0 && !o_ref_valid) else $error("ref level leak");
	AST_REF_VALID: assert property (o_ref_valid ==
		(o_neg_from_ref && i_converter_ref_field == 2'h3)) else $error("ref ok");
	AST_SYNC: assert property (!$past(i_rst) && !$past(i_rst, 2) |->
		o_cmp_output_sync == $past(i_cmp_raw, 2)) else $error("sync latency");
	AST_IRQ_GATE: assert property (o_cmp_irq_req |-> i_global_irq_enable)
		else $error("irq without global enable");
	AST_CAP_IN: assert property (o_capture_input |-> o_cmp_output_sync)
		else $error("capture input without output");
	AST_CAP_IRQ: assert property (o_capture_irq_req |->
		i_timer_capture_irq_enable && i_global_irq_enable) else $error("cap irq");
	AST_PIN_READ: assert property (o_pos_pin_read ==
		(i_pos_pin_digital && !o_pos_pin_buffer_off)) else $error("pin read");
endmodule
bind acc_top acc_top_props i_acc_top_props (.*);

// ---- acc_cmp_model.sv ----
/*
 Behavioural analog comparator core and timer capture front end.
 Assumes levels are plain codes driven by the bench.
*/
`timescale 1ns/1ns
module acc_cmp_model (
	input wire i_clk,
	input wire [7:0] i_pos_level,
	input wire [7:0] i_neg_level,
	input wire i_power_off,
	input wire i_capture_input,
	output logic o_raw,
	output logic o_capture_flag
);
	// Unpowered core gives a low output
	assign o_raw = !i_power_off && (i_pos_level > i_neg_level);
	initial o_capture_flag = 1'b0;
	always @(posedge i_clk) begin
		o_capture_flag <= i_capture_input;
	end
endmodule

// ---- acc_top_tb.sv ----
/*
 Self-checking bench for the comparator control top over APB.
 Assumes the behavioural core model drives the raw output.
*/
`timescale 1ns/1ns
`include "acc_defines.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[FAIL] %0t mismatch", $time); end end
module acc_top_tb;
int seed = 67683, n_mismatch = 0, comparisons = 0, tick = 0, i;
logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, cen = 0, gie = 0, er;
logic vec = 0, tce = 0, pd = 1, nd = 1;
logic [11:0] pa = 0;
logic [31:0] pw = 0, rd;
logic [4:0] code = 0;
logic [1:0] rf = 0;
logic [7:0] pos = 0, neg = 8'h80;
wire [31:0] prdata;
wire [4:0] pch;
wire [1:0] rlv;
wire pready, pslverr, pfm, pcv, csn, nref, rv, poff, sync, ireq, capi;
wire capq, prd, nrd, irq, raw, capf, pbo, nbo;
always #25 clk = ~clk;
acc_cmp_model i_acc_cmp_model (.i_clk(clk), .i_pos_level(pos),
	.i_neg_level(neg), .i_power_off(poff), .i_capture_input(capi),
	.o_raw(raw), .o_capture_flag(capf));
acc_top i_acc_top (.i_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_psel(psel),
	.i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pw),
	.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
	.i_cmp_raw(raw), .i_converter_enable(cen), .i_channel_select_code(code),
	.i_converter_ref_field(rf), .i_global_irq_enable(gie),
	.i_cmp_vector_taken(vec), .i_timer_capture_irq_enable(tce),
	.i_timer_capture_flag(capf), .i_pos_pin_digital(pd),
	.i_neg_pin_digital(nd), .o_pos_from_mux(pfm), .o_pos_channel(pch),
	.o_pos_channel_valid(pcv), .o_current_source_node(csn),
	.o_neg_from_ref(nref), .o_ref_level(rlv), .o_ref_valid(rv),
	.o_cmp_power_off(poff), .o_cmp_output_sync(sync), .o_cmp_irq_req(ireq),
	.o_capture_input(capi), .o_capture_irq_req(capq),
	.o_pos_pin_buffer_off(pbo), .o_neg_pin_buffer_off(nbo),
	.o_pos_pin_read(prd),
	.o_neg_pin_read(nrd), .o_irq(irq));
task finish_test;
	$display("checks %0d mismatches %0d", comparisons, n_mismatch);
	if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
	else $display("DONE - FAIL");
	$finish;
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
	@(posedge clk);
	psel <= 1;
	pwr <= w;
	pa <= a;
	pw <= d;
	@(posedge clk);
	pen <= 1;
	do @(posedge clk); while (pready !== 1'b1);
	rd = prdata;
	er = pslverr;
	psel <= 0;
	pen <= 0;
	#1;
endtask
function logic ev(input int m, input logic r);
	ev = m == 0 || (m == 3 && r) || (m == 2 && !r);
endfunction
always @(posedge clk) begin
	tick++;
	// Run needs well under this many cycles
	if (tick == 5000) begin
		n_mismatch++;
		finish_test;
	end
end
initial begin
	repeat (12) @(posedge clk);
	rst <= 0;
	for (i = 0; i < 6; i++) begin
		apb(0, 12'(i * 4), 0);
		`CHK(rd, 32'h0000_0000)
		`CHK(er, i == 5)
	end
	apb(1, `ACC_OFS_CTRL_B, 32'h0000_00FF);
	apb(0, `ACC_OFS_CTRL_B, 0);
	`CHK(rd, 32'h0000_00F7)
	$display("test reset done");
	apb(1, `ACC_OFS_CTRL_B, 32'h0000_0040);
	for (i = 0; i < 32; i++) begin
		code <= 5'(i);
		cen <= 1'($random(seed));
		@(posedge clk);
		#1;
		`CHK(pfm, !cen)
		`CHK(pch, cen ? 5'h00 : 5'(i))
		if (!cen) `CHK(pcv, i <= 10)
		`CHK(csn, !cen && i == 3)
	end
	for (i = 0; i < 8; i++) begin
		apb(1, `ACC_OFS_CTRL_B, 32'(i % 4) << 4);
		apb(1, `ACC_OFS_CSR, i > 3 ? 32'h0000_0040 : 0);
		rf <= 2'($random(seed));
		@(posedge clk);
		#1;
		`CHK(nref, i > 3)
		`CHK(rlv, i > 3 ? 2'(i % 4) : 2'h0)
		`CHK(rv, i > 3 && rf == 2'h3)
	end
	$display("test routing done");
	gie <= 1;
	for (i = 0; i < 4; i++) begin
		pos <= 8'($random(seed)) & 8'h7F;
		repeat (4) @(posedge clk);
		apb(1, `ACC_OFS_IRQ_MASK, 32'(i / 2));
		apb(1, `ACC_OFS_IRQ_STAT, 32'h0000_0003);
		apb(1, `ACC_OFS_CSR, 32'(i) | 32'h0000_0010);
		apb(1, `ACC_OFS_CSR, 32'(i) | 32'h0000_0018);
		pos <= 8'h81 | 8'($random(seed));
		repeat (4) @(posedge clk);
		#1;
		`CHK(ireq, ev(i, 1))
		`CHK(irq, ev(i, 1) && i > 1)
		apb(0, `ACC_OFS_CSR, 0);
		`CHK(rd[5:4], {1'b1, ev(i, 1)})
		apb(1, `ACC_OFS_CSR, 32'(i) | 32'h0000_0018);
		`CHK(ireq, 1'b0)
		pos <= 8'($random(seed)) & 8'h7F;
		repeat (4) @(posedge clk);
		#1;
		`CHK(ireq, ev(i, 0))
		vec <= 1;
		@(posedge clk);
		vec <= 0;
		#1;
		`CHK(ireq, 1'b0)
	end
	$display("test modes done");
	apb(1, `ACC_OFS_CSR, 32'h0000_0004);
	tce <= 1;
	pos <= 8'hC0;
	repeat (4) @(posedge clk);
	#1;
	`CHK(capi, 1'b1)
	`CHK(capq, 1'b1)
	tce <= 0;
	#1;
	`CHK(capq, 1'b0)
	apb(1, `ACC_OFS_CSR, 0);
	`CHK(capi, 1'b0)
	for (i = 0; i < 4; i++) begin
		apb(1, `ACC_OFS_DIDR, 32'(i) << 6);
		`CHK(prd, i < 2)
		`CHK(nrd, i % 2 == 0)
		`CHK(pbo, i >= 2)
		`CHK(nbo, i % 2 == 1)
	end
	apb(1, `ACC_OFS_CSR, 32'h0000_0080);
	`CHK(poff, 1'b1)
	$display("test capture pins power done");
	finish_test;
end
endmodule
